// [src/pcrm_defs.svh]
// Offsets, field positions, reset values and timing counts of the pulse monitor.
`ifndef PCRM_DEFS_SVH
`define PCRM_DEFS_SVH
`define OFS_CTL 6'h00
`define OFS_SCL 6'h04
`define OFS_SPT 6'h08
`define OFS_LIM 6'h0c
`define OFS_HYS 6'h10
`define OFS_DLY 6'h14
`define OFS_CMD 6'h18
`define OFS_ACC 6'h1c
`define OFS_CODE 6'h20
`define OFS_STAT 6'h24
`define OFS_CNT 6'h28
`define OFS_DISP 6'h2c
`define F_FUNC1 1:0
`define F_FUNC2 4:2
`define B_POL 5
`define B_SLOW 6
`define B_RSTEN 7
`define B_LEN1 8
`define B_LEN2 9
`define B_INV1 10
`define B_INV2 11
`define B_PLS1 12
`define B_PLS2 13
`define B_INDI 15
`define B_TMREN 16
`define F_DSEL 19:17
`define F_DP 21:20
`define F_LOW 9:0
`define F_HIGH 25:16
`define F_V14L 13:0
`define F_V14H 29:16
`define CTL_MASK 32'h003f_bfff
`define SCL_MASK 32'h03ff_03ff
`define SPT_MASK 32'h3fff_3fff
`define HYS_MASK 32'h03ff_3fff
`define CTL_RST 32'h0000_8380
`define SCL_RST 32'h0001_0001
`define SPT_RST 32'h0001_0001
`define LIM_RST 32'h0000_0000
`define HYS_RST 32'h0000_0001
`define DLY_RST 32'h0000_0000
`define CLK_NS 10
`define TICK_MS 100
`define TICK_CYC (`TICK_MS * 1000000 / `CLK_NS)
`define SLOW_MS 100
`define SLOW_CYC (`SLOW_MS * 1000000 / `CLK_NS)
`define FAST_US 10
`define FAST_CYC (`FAST_US * 1000 / `CLK_NS)
`define PULSE_MS 500
`define PULSE_TICKS (`PULSE_MS / `TICK_MS)
`define GATE_MS 1000
`define GATE_TICKS (`GATE_MS / `TICK_MS)
`define SHOW_S 60
`define SHOW_TICKS (`SHOW_S * 1000 / `TICK_MS)
`define DISP_MAX 9999
`define NEG_MIN 999
`define MUL_RPM 60
`define MUL_PPH 3600
`endif

// [src/pcrm_pkg.sv]
// Types of the pulse counter and rate monitor.
package pcrm_pkg;
    typedef enum logic [1:0] {M_CNT, M_RPM, M_FREQ, M_PPH} mode_e;
    typedef enum logic [2:0] {F2_CNT, F2_CNT1, F2_RPM, F2_FREQ, F2_PPH} mode2_e;
    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic [31:0] ctl;
        logic [31:0] scl;
        logic [31:0] spt;
        logic [31:0] lim;
        logic [31:0] hys;
        logic [31:0] dly;
        logic [1:0] acc;
        logic [15:0] code;
        logic [1:0] ps;
        logic [1:0] rs;
        logic pin_f;
        logic lp_prev;
        logic [23:0] flt_cnt;
        logic [23:0] tick_cnt;
        logic tick;
        logic [9:0] pc1;
        logic [9:0] pc2;
        logic [9:0] rtim;
        logic [15:0] cnt1;
        logic [15:0] cnt2;
        logic hit1;
        logic hit2;
        logic [2:0] pls1;
        logic [2:0] pls2;
        logic [3:0] gate;
        logic [13:0] gp;
        logic [13:0] rate;
        logic rate_ovr;
        logic hi_st;
        logic lo_st;
        logic trip;
        logic held1;
        logic held2;
        logic mon;
        logic [9:0] rcnt;
        logic [9:0] st_cnt;
        logic [9:0] show_tmr;
        logic show;
        logic relay1;
        logic relay2;
        logic hi_f;
        logic lo_f;
        logic ovr_f;
        logic [15:0] disp;
        logic [1:0] dp;
    } state_s;
endpackage : pcrm_pkg

// [src/pulse_counter_rate_monitor.sv]
// Pulse counter and rate monitor with two relay drives and an Avalon-MM register slave.
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
`include "pcrm_defs.svh"
//
// Operation
// - Pre-scaler divides pulses, 1 to 1000.
// - Each pre-scale completion adds post-scale amount.
// - Count reaching setpoint switches and holds relay.
// - Auto reset timer clears 0.1-99.9 s later.
// - Remaining display is setpoint minus count, min -999.
// - Above upper limit trips, recovers by hysteresis.
// - Below lower limit trips, recovers by hysteresis.
// - Hysteresis defaults to one.
// - Fault relay action de-energise or energise, configurable.
// - Latch holds tripped relay while pin low.
// - Latch release restarts start-up delay.
// - Faults ignored during start-up delay.
// - Fault must persist whole reaction delay.
// - High, low and over-range indications flagged.
// - Rate mode on relay one forces relay two.
// - Relay two counts pulses, setpoints or rate.
// - Reset and latch share one pin.
// - Clear command zeroes selected counter.
// - Pulse polarity selects close or open.
// - Fast 8000 Hz or slow 5 Hz filter.
// - Rate updates within 1.1 s; count quick.
// - Temporary rate display reverts after one minute.
// - Decimal setting selects four display formats.
// - Access code locks options; same code clears.
// - Reaction delay defaults to zero.
// - Counting relay pulse 0.5 s or continuous.
module pulse_counter_rate_monitor #(
    parameter logic [23:0] TICK_CYCLES = 24'(`TICK_CYC),
    parameter logic [23:0] SLOW_CYCLES = 24'(`SLOW_CYC)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Pins, low when contacts are closed
    input wire logic pulse_pin_n,
    input wire logic reset_latch_pin_n,
    // Relay drives, high energises
    output logic relay_one,
    output logic relay_two,
    // Indications
    output logic high_fault,
    output logic low_fault,
    output logic over_range_flag,
    output logic [15:0] display_value,
    output logic [1:0] decimal_sel
);
    pcrm_pkg::state_s s;
    pcrm_pkg::state_s n;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        logic acc;
        logic wr;
        logic cfg_ok;
        logic lvl;
        logic pulse_ev;
        logic lp;
        logic lp_rise;
        logic lp_fall;
        logic adv1;
        logic adv2;
        logic hit_ev1;
        logic rst1;
        logic rate1;
        logic rate2;
        logic act1;
        logic act2;
        logic fault1;
        logic fault2;
        logic raw_f;
        logic [9:0] pre;
        logic [9:0] post;
        logic [9:0] rdel;
        logic [13:0] up;
        logic [13:0] lo;
        logic [13:0] hy;
        logic [16:0] sum;
        logic [16:0] diff;
        logic [31:0] raw;
        logic [23:0] flim;
        logic [15:0] shown;
        pcrm_pkg::mode_e f1;
        pcrm_pkg::mode2_e f2;
        pcrm_pkg::mode_e kind;
        acc = 1'b0;
        wr = 1'b0;
        cfg_ok = 1'b0;
        lvl = 1'b0;
        pulse_ev = 1'b0;
        lp = 1'b0;
        lp_rise = 1'b0;
        lp_fall = 1'b0;
        adv1 = 1'b0;
        adv2 = 1'b0;
        hit_ev1 = 1'b0;
        rst1 = 1'b0;
        act1 = 1'b0;
        act2 = 1'b0;
        fault1 = 1'b0;
        fault2 = 1'b0;
        raw_f = 1'b0;
        sum = '0;
        diff = '0;
        raw = '0;
        shown = '0;
        n = s;
        f1 = pcrm_pkg::mode_e'(s.ctl[`F_FUNC1]);
        f2 = pcrm_pkg::mode2_e'(s.ctl[`F_FUNC2]);
        rate1 = (f1 != pcrm_pkg::M_CNT);
        rate2 = rate1 || (f2 == pcrm_pkg::F2_RPM) || (f2 == pcrm_pkg::F2_FREQ)
            || (f2 == pcrm_pkg::F2_PPH);
        pre = (s.scl[`F_LOW] == 10'h0) ? 10'h1 : s.scl[`F_LOW];
        post = (s.scl[`F_HIGH] == 10'h0) ? 10'h1 : s.scl[`F_HIGH];
        rdel = (s.hys[`F_HIGH] == 10'h0) ? 10'h1 : s.hys[`F_HIGH];
        up = s.lim[`F_V14L];
        lo = s.lim[`F_V14H];
        hy = s.hys[`F_V14L];

        // Common 0.1 s tick for every delay but the input filter, which counts clock cycles.
        n.tick = 1'b0;
        if (s.tick_cnt >= TICK_CYCLES - 24'h1) begin
            n.tick_cnt = '0;
            n.tick = 1'b1;
        end else begin
            n.tick_cnt = s.tick_cnt + 24'h1;
        end

        // ****************************************
        // Register slave
        // ****************************************
        acc = (avs_read | avs_write) & s.waitreq;
        wr = acc & avs_write;
        n.waitreq = ~acc;
        cfg_ok = wr & ~s.acc[0];
        if (cfg_ok) begin
            case (avs_address)
                `OFS_CTL: n.ctl = avs_writedata & `CTL_MASK;
                `OFS_SCL: n.scl = avs_writedata & `SCL_MASK;
                `OFS_SPT: n.spt = avs_writedata & `SPT_MASK;
                `OFS_LIM: n.lim = avs_writedata & `SPT_MASK;
                `OFS_HYS: n.hys = avs_writedata & `HYS_MASK;
                `OFS_DLY: n.dly = avs_writedata & `SCL_MASK;
                default: n.ctl = s.ctl;
            endcase
        end
        if (wr && avs_address == `OFS_ACC && s.code == 16'h0) begin
            n.acc = avs_writedata[1:0];
        end
        if (wr && avs_address == `OFS_CODE) begin
            if (s.code != 16'h0) begin
                if (avs_writedata[15:0] == s.code) begin
                    n.code = 16'h0;
                end
            end else begin
                n.code = avs_writedata[15:0];
            end
        end
        if (acc && avs_read) begin
            case (avs_address)
                `OFS_CTL: n.rdata = s.ctl;
                `OFS_SCL: n.rdata = s.scl;
                `OFS_SPT: n.rdata = s.spt;
                `OFS_LIM: n.rdata = s.lim;
                `OFS_HYS: n.rdata = s.hys;
                `OFS_DLY: n.rdata = s.dly;
                `OFS_ACC: n.rdata = {29'h0, (s.code != 16'h0), s.acc};
                `OFS_STAT: n.rdata = {24'h0, s.mon, s.show, s.hit2, s.hit1,
                    s.ovr_f, s.lo_f, s.hi_f, s.trip};
                `OFS_CNT: n.rdata = {s.cnt2, s.cnt1};
                `OFS_DISP: n.rdata = {14'h0, s.dp, s.disp};
                default: n.rdata = 32'h0;
            endcase
        end

        // ****************************************
        // Pin conditioning
        // ****************************************
        n.ps = {s.ps[0], pulse_pin_n};
        n.rs = {s.rs[0], reset_latch_pin_n};
        lvl = s.ctl[`B_POL] ? s.ps[1] : ~s.ps[1];
        flim = s.ctl[`B_SLOW] ? SLOW_CYCLES : 24'(`FAST_CYC);
        if (lvl != s.pin_f) begin
            if (s.flt_cnt >= flim - 24'h1) begin
                n.pin_f = lvl;
                n.flt_cnt = '0;
            end else begin
                n.flt_cnt = s.flt_cnt + 24'h1;
            end
        end else begin
            n.flt_cnt = '0;
        end
        pulse_ev = n.pin_f & ~s.pin_f;
        // One pin serves as relay-one reset and as latch.
        lp = ~s.rs[1];
        n.lp_prev = lp;
        lp_rise = lp & ~s.lp_prev;
        lp_fall = ~lp & s.lp_prev;

        // ****************************************
        // Counters
        // ****************************************
        if (!rate1 && pulse_ev) begin
            if (s.pc1 + 10'h1 >= pre) begin
                n.pc1 = '0;
                adv1 = 1'b1;
            end else begin
                n.pc1 = s.pc1 + 10'h1;
            end
        end
        if (adv1) begin
            sum = {1'b0, s.cnt1} + {7'h0, post};
            n.cnt1 = sum[16] ? 16'hffff : sum[15:0];
        end
        if (!rate1 && !s.hit1 && n.cnt1 >= {2'b0, s.spt[`F_V14L]}) begin
            n.hit1 = 1'b1;
            hit_ev1 = 1'b1;
            n.rtim = '0;
            n.pls1 = '0;
        end
        if (s.hit1 && s.tick) begin
            if (s.pls1 < 3'(`PULSE_TICKS)) begin
                n.pls1 = s.pls1 + 3'h1;
            end
            if (s.ctl[`B_TMREN]) begin
                if (s.rtim + 10'h1 >= rdel) begin
                    rst1 = 1'b1;
                end else begin
                    n.rtim = s.rtim + 10'h1;
                end
            end
        end
        if (s.ctl[`B_RSTEN] && lp_rise && !rate1) begin
            rst1 = 1'b1;
        end
        if (rst1 || (wr && avs_address == `OFS_CMD && avs_writedata[0])) begin
            n.cnt1 = '0;
            n.pc1 = '0;
            n.hit1 = 1'b0;
        end
        act1 = s.hit1 && (!s.ctl[`B_PLS1] || s.pls1 < 3'(`PULSE_TICKS));

        if (!rate2) begin
            if ((f2 == pcrm_pkg::F2_CNT && pulse_ev) || (f2 == pcrm_pkg::F2_CNT1 && hit_ev1)) begin
                if (s.pc2 + 10'h1 >= pre) begin
                    n.pc2 = '0;
                    adv2 = 1'b1;
                end else begin
                    n.pc2 = s.pc2 + 10'h1;
                end
            end
        end
        if (adv2) begin
            sum = {1'b0, s.cnt2} + {7'h0, post};
            n.cnt2 = sum[16] ? 16'hffff : sum[15:0];
        end
        if (!rate2 && !s.hit2 && n.cnt2 >= {2'b0, s.spt[`F_V14H]}) begin
            n.hit2 = 1'b1;
            n.pls2 = '0;
        end
        if (s.hit2 && s.tick && s.pls2 < 3'(`PULSE_TICKS)) begin
            n.pls2 = s.pls2 + 3'h1;
        end
        if (wr && avs_address == `OFS_CMD && avs_writedata[1]) begin
            n.cnt2 = '0;
            n.pc2 = '0;
            n.hit2 = 1'b0;
        end
        act2 = s.hit2 && (!s.ctl[`B_PLS2] || s.pls2 < 3'(`PULSE_TICKS));

        // ****************************************
        // Rate measurement over a 1 s gate
        // ****************************************
        kind = f1;
        if (!rate1) begin
            case (f2)
                pcrm_pkg::F2_RPM: kind = pcrm_pkg::M_RPM;
                pcrm_pkg::F2_PPH: kind = pcrm_pkg::M_PPH;
                default: kind = pcrm_pkg::M_FREQ;
            endcase
        end
        if (pulse_ev && s.gp != 14'h3fff) begin
            n.gp = s.gp + 14'h1;
        end
        if (s.tick) begin
            if (s.gate >= 4'(`GATE_TICKS - 1)) begin
                n.gate = '0;
                case (kind)
                    pcrm_pkg::M_RPM: raw = {18'h0, n.gp} * 32'd`MUL_RPM;
                    pcrm_pkg::M_PPH: raw = {18'h0, n.gp} * 32'd`MUL_PPH;
                    default: raw = {18'h0, n.gp};
                endcase
                n.rate_ovr = raw > 32'd`DISP_MAX;
                n.rate = n.rate_ovr ? 14'(`DISP_MAX) : raw[13:0];
                n.gp = '0;
            end else begin
                n.gate = s.gate + 4'h1;
            end
        end

        // ****************************************
        // Window comparator
        // ****************************************
        if (!s.mon) begin
            if (s.st_cnt >= s.dly[`F_LOW]) begin
                n.mon = 1'b1;
            end else if (s.tick) begin
                n.st_cnt = s.st_cnt + 10'h1;
            end
        end
        if (!s.mon || !rate2) begin
            n.hi_st = 1'b0;
            n.lo_st = 1'b0;
        end else begin
            if (up != 14'h0 && s.rate > up) begin
                n.hi_st = 1'b1;
            end else if (up == 14'h0 || {1'b0, s.rate} + {1'b0, hy} <= {1'b0, up}) begin
                n.hi_st = 1'b0;
            end
            if (lo != 14'h0 && s.rate < lo) begin
                n.lo_st = 1'b1;
            end else if (lo == 14'h0 || {1'b0, s.rate} >= {1'b0, lo} + {1'b0, hy}) begin
                n.lo_st = 1'b0;
            end
        end
        raw_f = s.hi_st | s.lo_st;
        if (!raw_f) begin
            n.rcnt = '0;
            n.trip = 1'b0;
        end else if (!s.trip) begin
            if (s.rcnt >= s.dly[`F_HIGH]) begin
                n.trip = 1'b1;
            end else if (s.tick) begin
                n.rcnt = s.rcnt + 10'h1;
            end
        end
        // A latched trip stays held while the pin is low.
        if (lp && s.trip && s.ctl[`B_LEN1]) begin
            n.held1 = 1'b1;
        end
        if (lp && s.trip && s.ctl[`B_LEN2]) begin
            n.held2 = 1'b1;
        end
        if (!lp) begin
            n.held1 = 1'b0;
            n.held2 = 1'b0;
        end
        if (lp_fall && rate2 && (s.ctl[`B_LEN1] || s.ctl[`B_LEN2])) begin
            n.mon = 1'b0;
            n.st_cnt = '0;
            n.hi_st = 1'b0;
            n.lo_st = 1'b0;
        end
        fault1 = s.trip | s.held1;
        fault2 = s.trip | s.held2;

        // ****************************************
        // Outputs
        // ****************************************
        if (rate1) begin
            n.relay1 = fault1 ? s.ctl[`B_INV1] : ~s.ctl[`B_INV1];
        end else begin
            n.relay1 = act1 ? ~s.ctl[`B_INV1] : s.ctl[`B_INV1];
        end
        if (rate2) begin
            n.relay2 = fault2 ? s.ctl[`B_INV2] : ~s.ctl[`B_INV2];
        end else begin
            n.relay2 = act2 ? ~s.ctl[`B_INV2] : s.ctl[`B_INV2];
        end
        n.hi_f = s.ctl[`B_INDI] & s.hi_st;
        n.lo_f = s.ctl[`B_INDI] & s.lo_st;
        n.ovr_f = rate2 ? s.rate_ovr : (s.cnt1 > 16'(`DISP_MAX));

        // Counting runs on while a rate value is shown for a while.
        if (!rate1 && wr && avs_address == `OFS_CMD && avs_writedata[2]) begin
            n.show = 1'b1;
            n.show_tmr = '0;
        end else if (s.show && s.tick) begin
            if (s.show_tmr >= 10'(`SHOW_TICKS - 1)) begin
                n.show = 1'b0;
            end else begin
                n.show_tmr = s.show_tmr + 10'h1;
            end
        end
        case (s.ctl[`F_DSEL])
            3'h1: diff = 17'({3'h0, s.spt[`F_V14L]}) - {1'b0, s.cnt1};
            3'h2: diff = {3'h0, s.rate};
            3'h3: diff = {1'b0, s.cnt2};
            3'h4: diff = 17'({3'h0, s.spt[`F_V14H]}) - {1'b0, s.cnt2};
            default: diff = {1'b0, s.cnt1};
        endcase
        if (rate1 || s.show) begin
            diff = {3'h0, s.rate};
        end
        if ($signed(diff) < -17'sd`NEG_MIN) begin
            shown = 16'(-`NEG_MIN);
        end else if (!diff[16] && diff[15:0] > 16'(`DISP_MAX)) begin
            shown = 16'(`DISP_MAX);
        end else begin
            shown = diff[15:0];
        end
        n.disp = shown;
        n.dp = s.ctl[`F_DP];
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '0;
            s.waitreq <= 1'b1;
            s.ctl <= `CTL_RST;
            s.scl <= `SCL_RST;
            s.spt <= `SPT_RST;
            s.lim <= `LIM_RST;
            s.hys <= `HYS_RST;
            s.dly <= `DLY_RST;
            s.ps <= 2'h3;
            s.rs <= 2'h3;
            s.relay1 <= 1'b1;
            s.relay2 <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign avs_readdata = s.rdata;
    assign avs_waitrequest = s.waitreq;
    assign relay_one = s.relay1;
    assign relay_two = s.relay2;
    assign high_fault = s.hi_f;
    assign low_fault = s.lo_f;
    assign over_range_flag = s.ovr_f;
    assign display_value = s.disp;
    assign decimal_sel = s.dp;
endmodule : pulse_counter_rate_monitor

// [test/pcrm_checker.sv]
// Checker of the bus handshake, reset state and display range of the pulse monitor.
`timescale 1ns/1ps
`include "pcrm_defs.svh"
module pcrm_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register bus
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Outputs
    input wire logic relay_one,
    input wire logic relay_two,
    input wire logic [15:0] display_value,
    input wire logic [1:0] decimal_sel
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence s_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    property p_handshake;
        s_take |=> s_ack;
    endproperty
    a_handshake: assert property (p_handshake) else $error("request not answered in one cycle"); // [CONTRACT]
    property p_quiet;
        !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_quiet: assert property (p_quiet) else $error("answer without request"); // [CONTRACT]
    property p_rst_bus;
        $rose(nrst) |-> avs_waitrequest && avs_readdata == 32'h0;
    endproperty
    a_rst_bus: assert property (p_rst_bus) else $error("bus not idle after reset"); // [CONTRACT]
    property p_rst_out;
        $rose(nrst) |-> relay_one && relay_two;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("relays not energised after reset");
    property p_rdata_hold;
        avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved between reads"); // [CONTRACT]
    property p_unmapped;
        avs_read && avs_waitrequest && avs_address > `OFS_DISP |=> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // [CONTRACT]
    property p_disp_range;
        $signed(display_value) >= -16'sd999 && $signed(display_value) <= 16'sd9999;
    endproperty
    a_disp_range: assert property (p_disp_range) else $error("display out of range");
    property p_dp_write;
        $changed(decimal_sel) |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3);
    endproperty
    a_dp_write: assert property (p_dp_write) else $error("decimal format moved without write");
endmodule : pcrm_checker

// [test/pulse_source.sv]
// Model of the pulse contact at the pulse input.
`timescale 1ns/1ps
module pulse_source (
    // Clock
    input wire logic clk,
    // Contact, low when closed, pulled high when open
    output logic pin_n
);
    // Each phase outlasts the fast filter, so the task returns with the pulse fully counted.
    localparam int HALF = 1100;
    initial begin
        pin_n = 1'b1;
    end
    task automatic send(input int n);
        repeat (n) begin
            pin_n <= 1'b0;
            repeat (HALF) @(posedge clk);
            pin_n <= 1'b1;
            repeat (HALF) @(posedge clk);
        end
    endtask : send
endmodule : pulse_source

// [test/pulse_counter_rate_monitor_tb_top.sv]
// Testbench of the pulse counter and rate monitor.
`timescale 1ns/1ps
`include "pcrm_defs.svh"
module pulse_counter_rate_monitor_tb_top;
    logic clk = 1'b0;
    logic nrst;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic pulse_pin_n;
    logic reset_latch_pin_n;
    logic relay_one, relay_two, high_fault, low_fault, over_range_flag;
    logic [15:0] display_value;
    logic [1:0] decimal_sel;
    logic [31:0] rd;
    logic [31:0] rst_tab [6] = '{`CTL_RST, `SCL_RST, `SPT_RST, `LIM_RST, `HYS_RST, `DLY_RST};
    int fail_count = 0;
    int n_compared = 0;
    pulse_counter_rate_monitor #(.TICK_CYCLES(24'd20), .SLOW_CYCLES(24'd50)) pulse_counter_rate_monitor_i (
        .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pulse_pin_n(pulse_pin_n), .reset_latch_pin_n(reset_latch_pin_n), .relay_one(relay_one),
        .relay_two(relay_two), .high_fault(high_fault), .low_fault(low_fault),
        .over_range_flag(over_range_flag), .display_value(display_value), .decimal_sel(decimal_sel));
    pulse_source pulse_source_i (.clk(clk), .pin_n(pulse_pin_n));
    initial begin
        forever #5 clk = ~clk;
    end
    // ****
    // Tasks
    // ****
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wait_r1(input logic v, input int lim);
        for (int i = 0; i < lim && relay_one !== v; i++) @(posedge clk);
    endtask : wait_r1
    task automatic summarize();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    initial begin
        #1_000_000;
        fail_count++;
        summarize();
    end
    // ****
    // Tests
    // ****
    initial begin
        nrst <= 1'b0;
        reset_latch_pin_n <= 1'b1;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, 6'(4 * i), 32'h0);
            chk("reset value", rd, rst_tab[i]);
        end
        bus(1'b0, 6'h30, 32'h0);
        chk("unmapped read", rd, 32'h0);
        bus(1'b1, `OFS_SCL, 32'h0003_0002);
        bus(1'b1, `OFS_SPT, 32'h0001_0006);
        bus(1'b1, `OFS_CTL, 32'h0022_8380);
        pulse_source_i.send(3);
        bus(1'b0, `OFS_CNT, 32'h0);
        chk("scaled count", 32'(rd[15:0]), 32'h3);
        chk("second count", 32'(rd[31:16]), 32'h3);
        chk("relay before setpoint", 32'(relay_one), 32'h0);
        chk("decimal format", 32'(decimal_sel), 32'h2);
        pulse_source_i.send(1);
        chk("relay at setpoint", 32'(relay_one), 32'h1);
        chk("remaining zero", 32'(display_value), 32'h0);
        pulse_source_i.send(2);
        chk("remaining negative", 32'(display_value), 32'h0000_fffd);
        chk("relay held", 32'(relay_one), 32'h1);
        bus(1'b1, `OFS_CMD, 32'h1);
        bus(1'b0, `OFS_CNT, 32'h0);
        chk("cleared count", 32'(rd[15:0]), 32'h0);
        pulse_source_i.send(4);
        // The shared pin acts as the counting reset here, since reset enable is on by default.
        reset_latch_pin_n <= 1'b0;
        repeat (1100) @(posedge clk);
        reset_latch_pin_n <= 1'b1;
        repeat (20) @(posedge clk);
        chk("relay reset by pin", 32'(relay_one), 32'h0);
        bus(1'b1, `OFS_HYS, 32'h0003_0001);
        bus(1'b1, `OFS_CTL, 32'h0023_8380);
        fork
            pulse_source_i.send(4);
            begin
                wait_r1(1'b1, 9000);
                repeat (35) @(posedge clk);
                chk("relay before timer", 32'(relay_one), 32'h1);
                wait_r1(1'b0, 200);
                chk("relay after timer", 32'(relay_one), 32'h0);
            end
        join
        bus(1'b0, `OFS_CNT, 32'h0);
        chk("count after timer", 32'(rd[15:0]), 32'h0);
        bus(1'b1, `OFS_ACC, 32'h1);
        bus(1'b1, `OFS_CODE, 32'h5);
        bus(1'b1, `OFS_CTL, 32'h0000_8381);
        bus(1'b1, `OFS_ACC, 32'h0);
        bus(1'b0, `OFS_ACC, 32'h0);
        chk("access with code", rd, 32'h5);
        bus(1'b1, `OFS_CODE, 32'h5);
        bus(1'b1, `OFS_ACC, 32'h0);
        bus(1'b0, `OFS_CTL, 32'h0);
        chk("config while locked", rd, 32'h0023_8380);
        bus(1'b0, `OFS_ACC, 32'h0);
        chk("access cleared", rd, 32'h0);
        bus(1'b1, `OFS_DLY, 32'h0000_0005);
        bus(1'b1, `OFS_CTL, 32'h0000_8381);
        wait_r1(1'b1, 500);
        chk("rate relay idle", 32'(relay_one), 32'h1);
        bus(1'b1, `OFS_LIM, 32'h000a_0000);
        wait_r1(1'b0, 2000);
        chk("low trip", 32'(relay_one), 32'h0);
        chk("low flag", 32'(low_fault), 32'h1);
        chk("high flag", 32'(high_fault), 32'h0);
        chk("no over-range", 32'(over_range_flag), 32'h0);
        chk("relay two follows", 32'(relay_two), 32'h0);
        reset_latch_pin_n <= 1'b0;
        bus(1'b1, `OFS_LIM, 32'h0);
        repeat (600) @(posedge clk);
        chk("latched relay", 32'(relay_one), 32'h0);
        bus(1'b1, `OFS_LIM, 32'h000a_0000);
        reset_latch_pin_n <= 1'b1;
        repeat (40) @(posedge clk);
        chk("start-up after release", 32'(relay_one), 32'h1);
        wait_r1(1'b0, 2000);
        chk("trip after start-up", 32'(relay_one), 32'h0);
        summarize();
    end
endmodule : pulse_counter_rate_monitor_tb_top
bind pulse_counter_rate_monitor pcrm_checker pcrm_checker_i (
    .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .relay_one(relay_one),
    .relay_two(relay_two), .display_value(display_value), .decimal_sel(decimal_sel));
